// ===== rtl/coproc_data_op_decode.sv
// Coprocessor data operation and software trap decoder with an AHB-Lite slave.
// Assumes a single master; software writes an instruction word, the block decides.
// Functional notes
// - Execute only when the condition field passes the current flags; else no effect.
// - Bits 27:24 equal 1110 mark a coprocessor operation; opcode in bits 23:20.
// - Operand A in 19:16, destination in 15:12, operand B in 3:0.
// - Bits 11:8 name the target coprocessor, 0 to 15.
// - Core looks only at bit 4 and bits 31:24; rest passes through.
// - Core gets no result and never waits for completion.
// - Cost is one sequential cycle plus one per busy-wait cycle.
// - No coprocessor exists, so every coprocessor instruction takes undefined trap.
// - The software trap comment field never affects execution.
// - Software trap enters supervisor, PC to 0x08, saves status register.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module coproc_data_op_decode
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  output logic             undef_trap,
  output logic             sw_trap
);

  // Width of the event status and mask words, declared before its first use.
  localparam int EV_W_L = cdp_decode_pkg::EV_W;

  // ==========================================================================
  // Register state.
  // ==========================================================================
  logic [31:0] instr_ff,     nxt_instr;
  logic [31:0] csr_ff,       nxt_csr;      // Current status register.
  logic [31:0] saved_ff,     nxt_saved;    // Supervisor or undefined saved status.
  logic [31:0] pc_ff,        nxt_pc;
  logic [3:0]  busy_ff,      nxt_busy;     // Busy-wait cycles to charge.
  logic [15:0] cycles_ff,    nxt_cycles;
  logic [EV_W_L-1:0] ev_ff,  nxt_ev;
  logic [EV_W_L-1:0] mask_ff, nxt_mask;
  logic [31:0] hrdata_ff,    nxt_hrdata;
  logic        irq_ff,       nxt_irq;
  logic        und_ff,       nxt_und;
  logic        swi_ff,       nxt_swi;
  logic        pend_ff,      nxt_pend;     // Instruction waiting for decode.
  logic        wr_ph_ff,     nxt_wr_ph;
  logic        rd_ph_ff,     nxt_rd_ph;
  logic [7:0]  addr_ff,      nxt_addr;

  // ==========================================================================
  // Decode of the held instruction word.
  // ==========================================================================
  logic cond_ok;
  logic is_coproc_class;
  logic is_cdp;
  logic is_trap;
  logic [3:0] cls;

  cond_check u_cond
  (
    .cond  (instr_ff[cdp_decode_pkg::COND_HI:cdp_decode_pkg::COND_LO]),
    .flags (csr_ff[31:28]),
    .pass  (cond_ok)
  );

  // Only bits 31:24 and bit 4 steer the core; the others are merely reported.
  assign cls = instr_ff[cdp_decode_pkg::CLASS_HI:cdp_decode_pkg::CLASS_LO];
  assign is_coproc_class = (cls == cdp_decode_pkg::CLASS_COPROC);
  assign is_cdp  = is_coproc_class && !instr_ff[cdp_decode_pkg::XFER_BIT];
  assign is_trap = (cls == cdp_decode_pkg::CLASS_TRAP);

  // ==========================================================================
  // Bus address phase capture.
  // ==========================================================================
  logic acc;
  assign acc = hsel && hready && htrans[1];

  always_comb
  begin
    nxt_wr_ph = acc && hwrite;
    nxt_rd_ph = acc && !hwrite;
    nxt_addr  = acc ? haddr[7:0] : addr_ff;
  end

  // Read data; the fields word shows opcode, operands, destination and number for a debugger.
  always_comb
  begin
    nxt_hrdata = 32'h0000_0000;
    if (acc && !hwrite)
    begin
      unique case (haddr[7:0])
        cdp_decode_pkg::REG_INSTR:    nxt_hrdata = instr_ff;
        cdp_decode_pkg::REG_STATUS:   nxt_hrdata = csr_ff;
        cdp_decode_pkg::REG_CTRL:     nxt_hrdata = {28'h0000000, busy_ff};
        cdp_decode_pkg::REG_FIELDS:   nxt_hrdata = {12'h000,
          instr_ff[cdp_decode_pkg::OPC_HI:cdp_decode_pkg::OPC_LO],
          instr_ff[cdp_decode_pkg::OPA_HI:cdp_decode_pkg::OPA_LO],
          instr_ff[cdp_decode_pkg::DEST_HI:cdp_decode_pkg::DEST_LO],
          instr_ff[cdp_decode_pkg::NUM_HI:cdp_decode_pkg::NUM_LO],
          instr_ff[cdp_decode_pkg::OPB_HI:cdp_decode_pkg::OPB_LO]};
        cdp_decode_pkg::REG_RESULT:   nxt_hrdata = pc_ff;
        cdp_decode_pkg::REG_IRQ_STAT: nxt_hrdata = {27'h0000000, ev_ff};
        cdp_decode_pkg::REG_IRQ_MASK: nxt_hrdata = {27'h0000000, mask_ff};
        cdp_decode_pkg::REG_CYCLES:   nxt_hrdata = {16'h0000, cycles_ff};
        default:                      nxt_hrdata = saved_ff;
      endcase
    end
  end

  // ==========================================================================
  // Execution and register writes. A write of the instruction word arms one
  // decode in the next cycle, so the bus never stalls: the core does not wait.
  // ==========================================================================
  logic [EV_W_L-1:0] ev_set;

  always_comb
  begin
    nxt_instr  = instr_ff;
    nxt_csr    = csr_ff;
    nxt_saved  = saved_ff;
    nxt_pc     = pc_ff;
    nxt_busy   = busy_ff;
    nxt_cycles = cycles_ff;
    nxt_mask   = mask_ff;
    nxt_pend   = 1'b0;
    nxt_und    = 1'b0;
    nxt_swi    = 1'b0;
    ev_set     = '0;
    if (pend_ff)
    begin
      if (!cond_ok)
        ev_set[cdp_decode_pkg::EV_SKIP] = 1'b1;
      else if (is_coproc_class)
      begin
        // No coprocessor is fitted, so the handler emulates it; no result returns.
        nxt_und   = 1'b1;
        nxt_saved = csr_ff;
        nxt_csr   = {csr_ff[31:5], cdp_decode_pkg::MODE_UND};
        nxt_pc    = cdp_decode_pkg::UNDEF_VECTOR;
        ev_set[cdp_decode_pkg::EV_UNDEF] = 1'b1;
        ev_set[cdp_decode_pkg::EV_CDP]   = is_cdp;
        nxt_cycles = 16'(cdp_decode_pkg::SEQ_CYCLES) + 16'(busy_ff);
      end
      else if (is_trap)
      begin
        nxt_swi   = 1'b1;
        nxt_saved = csr_ff;
        nxt_csr   = {csr_ff[31:5], cdp_decode_pkg::MODE_SVC};
        nxt_pc    = cdp_decode_pkg::SWTRAP_VECTOR;
        ev_set[cdp_decode_pkg::EV_SWI] = 1'b1;
      end
    end
    if (wr_ph_ff)
    begin
      unique case (addr_ff)
        cdp_decode_pkg::REG_INSTR:
        begin
          nxt_instr = hwdata;
          nxt_pend  = 1'b1;
        end
        cdp_decode_pkg::REG_STATUS:   nxt_csr  = hwdata;
        cdp_decode_pkg::REG_CTRL:     nxt_busy = hwdata[3:0];
        cdp_decode_pkg::REG_IRQ_MASK: nxt_mask = hwdata[EV_W_L-1:0];
        default:                      nxt_pend = 1'b0;
      endcase
    end
    // A read clears the status, but a new event in the same cycle survives.
    nxt_ev = ((rd_ph_ff && addr_ff == cdp_decode_pkg::REG_IRQ_STAT) ? '0 : ev_ff) | ev_set;
    nxt_irq = |(nxt_ev & nxt_mask);
  end

  // ==========================================================================
  // Registers; clock enable freezes everything.
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_ff  <= 32'h0000_0000;
      csr_ff    <= cdp_decode_pkg::CSR_RESET;
      saved_ff  <= 32'h0000_0000;
      pc_ff     <= 32'h0000_0000;
      busy_ff   <= 4'h0;
      cycles_ff <= 16'h0000;
      ev_ff     <= '0;
      mask_ff   <= '0;
      hrdata_ff <= 32'h0000_0000;
      irq_ff    <= 1'b0;
      und_ff    <= 1'b0;
      swi_ff    <= 1'b0;
      pend_ff   <= 1'b0;
      wr_ph_ff  <= 1'b0;
      rd_ph_ff  <= 1'b0;
      addr_ff   <= 8'h00;
    end
    else if (clk_en)
    begin
      instr_ff  <= nxt_instr;
      csr_ff    <= nxt_csr;
      saved_ff  <= nxt_saved;
      pc_ff     <= nxt_pc;
      busy_ff   <= nxt_busy;
      cycles_ff <= nxt_cycles;
      ev_ff     <= nxt_ev;
      mask_ff   <= nxt_mask;
      hrdata_ff <= nxt_hrdata;
      irq_ff    <= nxt_irq;
      und_ff    <= nxt_und;
      swi_ff    <= nxt_swi;
      pend_ff   <= nxt_pend;
      wr_ph_ff  <= nxt_wr_ph;
      rd_ph_ff  <= nxt_rd_ph;
      addr_ff   <= nxt_addr;
    end
  end

  // Zero wait states and always OKAY.
  assign hrdata     = hrdata_ff;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign irq        = irq_ff;
  assign undef_trap = und_ff;
  assign sw_trap    = swi_ff;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  skip_no_trap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pend_ff && !cond_ok |=> !und_ff && !swi_ff)
    else $error("Failed condition still trapped.");
  coproc_undef_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pend_ff && cond_ok && is_coproc_class |=> und_ff && pc_ff == 32'h0000_0004)
    else $error("Coprocessor instruction missed undefined trap.");
  swi_vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pend_ff && cond_ok && is_trap |=> swi_ff && pc_ff == 32'h0000_0008
      && csr_ff[4:0] == 5'h13 && saved_ff == $past(csr_ff))
    else $error("Software trap entry wrong.");
  comment_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
    swi_ff |-> $past(instr_ff[27:24]) == 4'hF)
    else $error("Trap raised by wrong class.");
  cdp_bit4_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pend_ff && cond_ok && is_coproc_class && instr_ff[4] |=> !ev_ff[0])
    else $error("Transfer counted as data operation.");
  cycle_cost_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && pend_ff && cond_ok && is_coproc_class |=> cycles_ff == 16'($past(busy_ff)) + 16'h1)
    else $error("Cycle cost wrong.");
  no_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("Bus stalled.");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> irq == |(ev_ff & mask_ff))
    else $error("Interrupt level mismatch.");

endmodule

// ===== rtl/cdp_decode_pkg.sv
// Package with the constants shared by the coprocessor data operation decoder.
// Assumes a 32-bit instruction word and a 32-bit AHB-Lite register bus.
package cdp_decode_pkg;

  // ==========================================================================
  // Instruction fields.
  // ==========================================================================
  localparam int COND_HI       = 31;
  localparam int COND_LO       = 28;
  localparam int CLASS_HI      = 27;
  localparam int CLASS_LO      = 24;
  localparam int OPC_HI        = 23;
  localparam int OPC_LO        = 20;
  localparam int OPA_HI        = 19;
  localparam int OPA_LO        = 16;
  localparam int DEST_HI       = 15;
  localparam int DEST_LO       = 12;
  localparam int NUM_HI        = 11;
  localparam int NUM_LO        = 8;
  localparam int INFO_HI       = 7;
  localparam int INFO_LO       = 5;
  localparam int XFER_BIT      = 4;
  localparam int OPB_HI        = 3;
  localparam int OPB_LO        = 0;
  localparam logic [3:0] CLASS_COPROC = 4'hE;
  localparam logic [3:0] CLASS_TRAP   = 4'hF;

  // ==========================================================================
  // Trap entry and cycle cost.
  // ==========================================================================
  localparam logic [31:0] SWTRAP_VECTOR = 32'h0000_0008;
  localparam logic [31:0] UNDEF_VECTOR  = 32'h0000_0004;
  localparam logic [4:0]  MODE_SVC      = 5'h13;
  localparam logic [4:0]  MODE_UND      = 5'h1B;
  localparam int          SEQ_CYCLES    = 1;

  // ==========================================================================
  // Register map, byte addresses.
  // ==========================================================================
  localparam logic [7:0] REG_INSTR    = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CTRL     = 8'h08;
  localparam logic [7:0] REG_FIELDS   = 8'h0C;
  localparam logic [7:0] REG_RESULT   = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_CYCLES   = 8'h1C;
  localparam logic [31:0] CSR_RESET   = 32'h0000_00D3;

  // Event bits in the interrupt status and mask registers.
  localparam int EV_CDP   = 0;
  localparam int EV_UNDEF = 1;
  localparam int EV_SWI   = 2;
  localparam int EV_SKIP  = 3;
  localparam int EV_W     = 4;

endpackage

// ===== rtl/cond_check.sv
// Condition field evaluator against the N, Z, C and V flags.
// Assumes the flags arrive as a stable word in the same clock domain.
`timescale 1ns/1ps
module cond_check
(
  input  wire logic [3:0] cond,
  input  wire logic [3:0] flags,
  output logic            pass
);

  logic n;
  logic z;
  logic c;
  logic v;
  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];

  // ==========================================================================
  // Condition table; code 4'hF is treated as never.
  // ==========================================================================
  always_comb
  begin
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'hA: pass = (n == v);
      4'hB: pass = (n != v);
      4'hC: pass = !z && (n == v);
      4'hD: pass = z || (n != v);
      4'hE: pass = 1'b1;
      4'hF: pass = 1'b0;
    endcase
  end

endmodule

// ===== verif/coproc_emulator.sv
// Behavioural stand-in for the trap-handler emulation of one coprocessor.
// Assumes the bench hands it the instruction word last written to the block.
`timescale 1ns/1ps
module coproc_emulator
#(
  parameter logic [3:0] MY_NUM = 4'h5
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        trap,
  input  wire logic [31:0] instr,
  output logic [7:0]       handled,
  output logic [31:0]      result
);
  // ==========================================================================
  // Emulated data operation.
  // ==========================================================================
  // Only data operations that carry our own number are taken up.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      handled <= 8'h00;
      result  <= 32'h0000_0000;
    end
    else if (trap && !instr[4] && instr[11:8] == MY_NUM)
    begin
      handled <= handled + 8'h01;
      // Opcode and info field mix with the operand indices; the destination index sits above them.
      result  <= {21'h0, instr[15:12], instr[23:20] ^ instr[19:16], instr[7:5] ^ instr[3:1]};
    end
  end
endmodule

// ===== verif/coproc_data_op_decode_test.sv
// Self-checking bench for the coprocessor data operation decoder.
// Assumes a single AHB-Lite master and a zero-wait slave, 25 MHz clock.
`timescale 1ns/1ps
module coproc_data_op_decode_test;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        undef_trap;
  logic        sw_trap;
  logic [31:0] instr_q;
  logic [7:0]  handled;
  logic [7:0]  exp_h;
  logic [31:0] rd;
  int          err_total;
  int          tests_run;
  localparam logic [31:0] SMASK = 32'hF000_001F;

  coproc_data_op_decode i_coproc_data_op_decode (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .undef_trap(undef_trap),
    .sw_trap(sw_trap));
  coproc_emulator i_coproc_emulator (.hclk(hclk), .hresetn(hresetn), .trap(undef_trap),
    .instr(instr_q), .handled(handled), .result());

  // ==========================================================================
  // Clock, checks and verdict.
  // ==========================================================================
  always #20 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One single transfer; the address phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready_ok() == 1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready_ok() == 1'b0);
    r = hrdata;
  endtask

  function automatic logic hready_ok();
    return hreadyout === 1'b1;
  endfunction

  // Condition codes in pairs: odd codes invert the even one, code 15 never passes.
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & !f[2];
      3'h5: r = (f[3] == f[0]);
      3'h6: r = !f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return r ^ c[0];
  endfunction

  // ==========================================================================
  // One instruction with random flags, busy-wait count and mask.
  // ==========================================================================
  task automatic run_one(input int i);
    logic [31:0] ins;
    logic [31:0] st;
    logic [3:0]  b;
    logic [3:0]  m;
    logic [3:0]  ist;
    logic [7:0]  cu;
    logic [7:0]  cs;
    logic        go;
    logic        cop;
    logic [31:0] corner [4];
    corner = '{32'hEE12_3405, 32'hFF00_0000, 32'hEEAB_CD1F, 32'h0F12_3456};
    ins = $urandom;
    ins[27:24] = ($urandom % 3 == 0) ? cdp_decode_pkg::CLASS_TRAP : cdp_decode_pkg::CLASS_COPROC;
    b = 4'($urandom);
    m = 4'($urandom);
    if (i < 4)
    begin
      ins = corner[i];
      b = 4'(i * 5);
    end
    st = {4'($urandom), 20'h0, 8'h10};
    go = cond_ok(ins[31:28], st[31:28]);
    cop = (ins[27:24] == cdp_decode_pkg::CLASS_COPROC);
    bus(1'b1, cdp_decode_pkg::REG_STATUS, st, rd);
    bus(1'b1, cdp_decode_pkg::REG_CTRL, {28'h0, b}, rd);
    bus(1'b1, cdp_decode_pkg::REG_IRQ_MASK, {28'h0, m}, rd);
    instr_q = ins;
    bus(1'b1, cdp_decode_pkg::REG_INSTR, ins, rd);
    cu = 8'h00;
    cs = 8'h00;
    repeat (4)
    begin
      @(posedge hclk);
      #1;
      cu = cu + {7'h0, undef_trap};
      cs = cs + {7'h0, sw_trap};
    end
    check({24'h0, cu}, {31'h0, go & cop});
    check({24'h0, cs}, {31'h0, go & !cop});
    check({31'h0, hreadyout}, 32'h1);
    ist = !go ? 4'h8 : (cop ? {3'b001, !ins[4]} : 4'h4);
    check({31'h0, irq}, {31'h0, |(ist & m)});
    bus(1'b0, cdp_decode_pkg::REG_IRQ_STAT, 32'h0, rd);
    check(rd & 32'hF, {28'h0, ist});
    bus(1'b0, cdp_decode_pkg::REG_IRQ_STAT, 32'h0, rd);
    check(rd & 32'hF, 32'h0);
    @(posedge hclk);
    #1;
    check({31'h0, irq}, 32'h0);
    bus(1'b0, cdp_decode_pkg::REG_STATUS, 32'h0, rd);
    check(rd & SMASK, !go ? (st & SMASK) : {st[31:28], 23'h0,
          cop ? cdp_decode_pkg::MODE_UND : cdp_decode_pkg::MODE_SVC});
    if (go)
    begin
      bus(1'b0, cdp_decode_pkg::REG_RESULT, 32'h0, rd);
      check(rd, cop ? cdp_decode_pkg::UNDEF_VECTOR : cdp_decode_pkg::SWTRAP_VECTOR);
      bus(1'b0, 8'h20, 32'h0, rd);
      check(rd & SMASK, st & SMASK);
    end
    if (go && cop)
    begin
      bus(1'b0, cdp_decode_pkg::REG_CYCLES, 32'h0, rd);
      check(rd, {28'h0, b} + 32'(cdp_decode_pkg::SEQ_CYCLES));
      if (!ins[4])
      begin
        bus(1'b0, cdp_decode_pkg::REG_FIELDS, 32'h0, rd);
        check(rd, {12'h0, ins[23:8], ins[3:0]});
        exp_h = exp_h + {7'h0, ins[11:8] == 4'h5};
      end
    end
  endtask

  // ==========================================================================
  // Main sequence and watchdog.
  // ==========================================================================
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    instr_q = 32'h0;
    exp_h = 8'h00;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h2669));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, cdp_decode_pkg::REG_STATUS, 32'h0, rd);
    check(rd, cdp_decode_pkg::CSR_RESET);
    bus(1'b0, cdp_decode_pkg::REG_IRQ_STAT, 32'h0, rd);
    check(rd, 32'h0);
    // Unmapped and read-only places must shrug off writes.
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
    bus(1'b1, cdp_decode_pkg::REG_RESULT, 32'h0000_0055, rd);
    bus(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 200; i++)
      run_one(i);
    check({24'h0, handled}, {24'h0, exp_h});
    results();
  end

  // Tests take about 4400 cycles; four and a half times that means a hang.
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    results();
  end
endmodule
